// ==== design/med_params.svh ====
// Constants, register map and timing of the motion event detector
// Functional notes
// - Store new filtered axis samples once per interval picked by the active rate, or by the low rate in watch.
// - Each axis sample is the average of 32 consecutive readings.
// - Each event class raises the interrupt only when its own enable is set.
// - No readings are taken in standby or in test mode.
// - Orientation candidates are computed every sample, stored only per debounce.
// - Debounce length zero stores the computed orientation after every sample.
// - Nonzero debounce length needs that many matching consecutive readings first.
// - Debounce count clears on mismatch and whenever the orientation status updates.
// - Orientation classified from axis magnitudes, signs and the 0.8g/0.25g limits.
// - Enabled axis beyond plus or minus 1.3g declares shake with an interrupt.
// - Axes tested separately; one shared shake flag, no axis recorded.
// - Reading orientation status clears shake during the acknowledge; monitoring restarts.
// - Tap is a fast change above the threshold lasting the duration count.
// - Tap detection ORs the selected axes and reports through the tap flag.
// - Tap flag set pauses tap detection until orientation status is read.
// - Delta G works at any rate with all three axis selects set.
// - Watch state samples at the low rate, leaves it on any activity.
// - Doze state samples at the active rate, returns to watch on expiry when watch is enabled.
// - Activity wakes and resets the sleep count; expiry alone triggers sleep.
// - Entering measurement starts in watch if enabled, else doze if enabled.
// - Each sample is a 6-bit value in its own per-axis register.
// - Landscape codes 000/001/010/101/110; face codes 00/01/10.
// - Reading an axis or status register while it updates sets its alert bit.
// - Eight-bit sleep counter runs to its limit; writing the limit resets it.
`ifndef MED_PARAMS_SVH
`define MED_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define MED_ADDR_X     5'h00
`define MED_ADDR_Y     5'h01
`define MED_ADDR_Z     5'h02
`define MED_ADDR_STAT   5'h03
`define MED_ADDR_SRST   5'h04
`define MED_ADDR_SLEEP  5'h05
`define MED_ADDR_IRQ    5'h06
`define MED_ADDR_MODE   5'h07
`define MED_ADDR_RATE   5'h08
`define MED_ADDR_TAPTH  5'h09
`define MED_ADDR_TAPDUR 5'h0A
`define MED_REG_RESET  8'h00

// ****************************************
// field positions
// ****************************************
`define MED_MODE_ON  0
`define MED_MODE_TON 2
`define MED_MODE_WATCH 3
`define MED_MODE_DOZE  4
`define MED_MODE_IPP 6
`define MED_MODE_IAH 7
`define MED_EN_FB    0
`define MED_EN_PL    1
`define MED_EN_TAP   2
`define MED_EN_AS    3
`define MED_EN_G     4

// ****************************************
// codes, thresholds and timing
// ****************************************
`define MED_PL_UNK   3'h0
`define MED_PL_LEFT  3'h1
`define MED_PL_RIGHT 3'h2
`define MED_PL_DOWN  3'h5
`define MED_PL_UP    3'h6
`define MED_FB_UNK   2'h0
`define MED_FB_FRONT 2'h1
`define MED_FB_BACK  2'h2
`define MED_Z_08G    6'h11
`define MED_Z_POS    6'sh05
`define MED_Z_NEG    6'sh3B
`define MED_SHK_POS  6'sh1C
`define MED_SHK_NEG  6'sh24
`define MED_AVG_LAST 5'h1F
`define MED_CLK_MHZ  250
`define MED_T120_US  8360
`define MED_T64_US   15625
`define MED_T32_US   31250
`define MED_T16_US   62500
`define MED_T8_US    125000
`define MED_T4_US    250000
`define MED_T2_US    500000
`define MED_T1_US    1000000

`endif

// ==== design/med_pkg.sv ====
// Types shared by the motion event detector
`include "med_params.svh"
package med_pkg;

    typedef logic signed [5:0] med_axis_t;

    // operating states, gray coded along standby-active-doze-watch
    typedef enum logic [1:0] {
        MED_STANDBY = 2'h0,
        MED_ACTIVE  = 2'h1,
        MED_DOZE    = 2'h3,
        MED_WATCH   = 2'h2
    } med_state_t;

    typedef struct packed {
        med_axis_t x;
        med_axis_t y;
        med_axis_t z;
    } med_axes_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } med_req_t;

    typedef struct packed {
        med_state_t        st;
        logic [27:0]       div_cnt;
        logic              burst;
        logic [4:0]        rd_cnt;
        logic signed [10:0] acc_x;
        logic signed [10:0] acc_y;
        logic signed [10:0] acc_z;
        med_axes_t         smp;
        med_axes_t         prev;
        logic              smp_go;
        logic [4:0]        cand;
        logic [2:0]        db_cnt;
        logic [2:0]        pl_code;
        logic [1:0]        fb_code;
        logic              shake;
        logic              tap;
        logic [7:0]        tap_cnt;
        logic [7:0]        sleep_cnt;
        logic [7:0]        sleep_lim;
        logic [7:0]        irq_en;
        logic [7:0]        mode;
        logic [7:0]        rate_cfg;
        logic [7:0]        tap_cfg;
        logic [7:0]        tap_dur;
        logic              pend;
        logic [7:0]        rdata;
        logic              int_o;
        logic              int_oe;
    } med_st_t;

endpackage : med_pkg

// ==== design/med_top.sv ====
// Digital analysis logic of the three-axis motion event detector
`timescale 1ns/100ps
`include "med_params.svh"
module med_top #(
    parameter int CYC_PER_US = `MED_CLK_MHZ
) (
    // clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RESET_N,
    // converter readings
    input  wire logic              ADC_VALID,
    input  wire med_pkg::med_axes_t ADC_SAMPLE,
    // register access
    input  wire med_pkg::med_req_t REG_REQ,
    output logic [7:0]             REG_RDATA,
    // interrupt pin
    output logic                   INT_O,
    output logic                   INT_OE
);

    // ****************************************
    // parameter check
    // ****************************************
    if (CYC_PER_US < 1 || CYC_PER_US > 268) begin : g_bad_rate
        $error("CYC_PER_US out of range for the 28-bit interval divider");
    end

    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic [5:0] med_abs(med_pkg::med_axis_t v);
        med_abs = v[5] ? 6'(-v) : 6'(v);
    endfunction : med_abs

    // beyond plus or minus 1.3g
    function automatic logic med_over(med_pkg::med_axis_t v);
        med_over = (v > `MED_SHK_POS) || (v < `MED_SHK_NEG);
    endfunction : med_over

    // orientation classes
    // returns {landscape code, face code}
    function automatic logic [4:0] med_orient(med_pkg::med_axes_t a);
        logic [5:0] ax;
        logic [5:0] ay;
        logic [2:0] pl;
        logic [1:0] fb;
        ax = med_abs(a.x);
        ay = med_abs(a.y);
        pl = `MED_PL_UNK;
        fb = `MED_FB_UNK;
        if (med_abs(a.z) < `MED_Z_08G) begin
            if (ax > ay) begin
                pl = a.x[5] ? `MED_PL_UP : `MED_PL_DOWN;
            end else if (ay > ax) begin
                pl = a.y[5] ? `MED_PL_RIGHT : `MED_PL_LEFT;
            end
        end
        if (a.z > `MED_Z_POS) begin
            fb = `MED_FB_FRONT;
        end else if (a.z < `MED_Z_NEG) begin
            fb = `MED_FB_BACK;
        end
        med_orient = {pl, fb};
    endfunction : med_orient

    // fast change on one axis above the tap threshold
    function automatic logic med_jump(med_pkg::med_axis_t a, med_pkg::med_axis_t b,
                                      logic [4:0] th);
        logic signed [6:0] d;
        d = 7'(a) - 7'(b);
        med_jump = (d[6] ? 7'(-d) : d) > {2'h0, th};
    endfunction : med_jump

    // interval length in cycles; watch uses the low-rate selector
    function automatic logic [27:0] med_period(logic watch, logic [2:0] am, logic [1:0] aw);
        int us;
        if (watch) begin
            case (aw)
                2'h0:    us = `MED_T32_US;
                2'h1:    us = `MED_T16_US;
                2'h2:    us = `MED_T8_US;
                default: us = `MED_T1_US;
            endcase
        end else begin
            case (am)
                3'h0:    us = `MED_T120_US;
                3'h1:    us = `MED_T64_US;
                3'h2:    us = `MED_T32_US;
                3'h3:    us = `MED_T16_US;
                3'h4:    us = `MED_T8_US;
                3'h5:    us = `MED_T4_US;
                3'h6:    us = `MED_T2_US;
                default: us = `MED_T1_US;
            endcase
        end
        med_period = 28'(us * CYC_PER_US);
    endfunction : med_period

    // ****************************************
    // state and intermediates
    // ****************************************
    med_pkg::med_st_t   q_reg;
    med_pkg::med_st_t   q_next;
    logic               active;
    logic               stat_rd;
    logic [27:0]        period_c;
    logic signed [10:0] sum_x;
    logic signed [10:0] sum_y;
    logic signed [10:0] sum_z;
    logic [4:0]         cand;
    logic [2:0]         db_c;
    logic               axis_upd;
    logic               ori_upd;
    logic               pl_chg;
    logic               fb_chg;
    logic               ev_shake;
    logic               ev_tap;
    logic               ev_as;
    logic               activity;
    logic               tap_run;
    logic [7:0]         rd_val;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        q_next   = q_reg;
        active   = q_reg.mode[`MED_MODE_ON] & ~q_reg.mode[`MED_MODE_TON];
        stat_rd  = REG_REQ.rd && (REG_REQ.addr == `MED_ADDR_STAT);
        period_c = med_period(q_reg.st == med_pkg::MED_WATCH, q_reg.rate_cfg[2:0],
                              q_reg.rate_cfg[4:3]);
        sum_x    = q_reg.acc_x + 11'(ADC_SAMPLE.x);
        sum_y    = q_reg.acc_y + 11'(ADC_SAMPLE.y);
        sum_z    = q_reg.acc_z + 11'(ADC_SAMPLE.z);
        cand     = med_orient(q_reg.smp);
        db_c     = 3'h0;
        axis_upd = 1'b0;
        ori_upd  = 1'b0;
        pl_chg   = 1'b0;
        fb_chg   = 1'b0;
        ev_shake = 1'b0;
        ev_tap   = 1'b0;
        ev_as    = 1'b0;
        tap_run  = 1'b0;
        q_next.smp_go = 1'b0;

        // operating state on entry and exit of measurement
        if (!q_reg.mode[`MED_MODE_ON]) begin
            q_next.st = med_pkg::MED_STANDBY;
        end else if (q_reg.st == med_pkg::MED_STANDBY && active) begin
            if (q_reg.mode[`MED_MODE_WATCH]) begin
                q_next.st = med_pkg::MED_WATCH;
            end else if (q_reg.mode[`MED_MODE_DOZE]) begin
                q_next.st = med_pkg::MED_DOZE;
            end else begin
                q_next.st = med_pkg::MED_ACTIVE;
            end
        end

        if (!active) begin
            q_next.div_cnt = 28'h0;
            q_next.burst   = 1'b0;
        end else if (q_reg.div_cnt >= period_c - 28'h1) begin
            q_next.div_cnt = 28'h0;
            q_next.burst   = 1'b1;
            q_next.rd_cnt  = 5'h0;
            q_next.acc_x   = 11'sh000;
            q_next.acc_y   = 11'sh000;
            q_next.acc_z   = 11'sh000;
        end else begin
            q_next.div_cnt = q_reg.div_cnt + 28'h1;
        end

        // average of 32 readings, truncated to 6 bits
        if (active && q_reg.burst && ADC_VALID) begin
            q_next.acc_x  = sum_x;
            q_next.acc_y  = sum_y;
            q_next.acc_z  = sum_z;
            q_next.rd_cnt = q_reg.rd_cnt + 5'h1;
            if (q_reg.rd_cnt == `MED_AVG_LAST) begin
                q_next.burst  = 1'b0;
                q_next.smp    = {sum_x[10:5], sum_y[10:5], sum_z[10:5]};
                q_next.smp_go = 1'b1;
                axis_upd      = 1'b1;
            end
        end

        // test mode: written axis values drive the analysis instead
        if (REG_REQ.wr && q_reg.mode[`MED_MODE_TON] && REG_REQ.addr <= `MED_ADDR_Z) begin
            case (REG_REQ.addr)
                `MED_ADDR_X: q_next.smp.x = REG_REQ.wdata[5:0];
                `MED_ADDR_Y: q_next.smp.y = REG_REQ.wdata[5:0];
                default:     q_next.smp.z = REG_REQ.wdata[5:0];
            endcase
            q_next.smp_go = 1'b1;
            axis_upd      = 1'b1;
        end

        // status read clears first, so a same-cycle event wins
        if (stat_rd) begin
            q_next.shake = 1'b0;
            q_next.tap   = 1'b0;
            q_next.pend  = 1'b0;
        end

        // analysis of the sample stored on the previous cycle
        if (q_reg.smp_go) begin
            db_c        = (cand != q_reg.cand) ? 3'h0 :
                          (q_reg.db_cnt == 3'h7) ? 3'h7 : q_reg.db_cnt + 3'h1;
            q_next.cand = cand;
            // store when the count meets the debounce length
            if (q_reg.rate_cfg[7:5] == 3'h0 || db_c >= q_reg.rate_cfg[7:5]) begin
                ori_upd        = 1'b1;
                pl_chg         = q_reg.pl_code != cand[4:2];
                fb_chg         = q_reg.fb_code != cand[1:0];
                q_next.pl_code = cand[4:2];
                q_next.fb_code = cand[1:0];
                db_c         = 3'h0;
            end
            q_next.db_cnt = db_c;

            // per-axis test into one shared flag
            if (!q_reg.shake && |(q_reg.irq_en[7:5] &
                {med_over(q_reg.smp.x), med_over(q_reg.smp.y), med_over(q_reg.smp.z)})) begin
                ev_shake     = 1'b1;
                q_next.shake = 1'b1;
            end

            // tap at full rate, delta G at any rate with all axes
            tap_run = !q_reg.tap && q_reg.st != med_pkg::MED_STANDBY &&
                      (q_reg.rate_cfg[2:0] == 3'h0 || q_reg.tap_cfg[7:5] == 3'h7);
            if (tap_run && |(q_reg.tap_cfg[7:5] &
                {med_jump(q_reg.smp.z, q_reg.prev.z, q_reg.tap_cfg[4:0]),
                 med_jump(q_reg.smp.y, q_reg.prev.y, q_reg.tap_cfg[4:0]),
                 med_jump(q_reg.smp.x, q_reg.prev.x, q_reg.tap_cfg[4:0])})) begin
                if (q_reg.tap_cnt >= q_reg.tap_dur) begin
                    ev_tap         = 1'b1;
                    q_next.tap     = q_reg.irq_en[`MED_EN_TAP];
                    q_next.tap_cnt = 8'h00;
                end else begin
                    q_next.tap_cnt = q_reg.tap_cnt + 8'h01;
                end
            end else if (tap_run) begin
                q_next.tap_cnt = 8'h00;
            end
            q_next.prev = q_reg.smp;

            activity = pl_chg | fb_chg | ev_shake | ev_tap;
            if (q_reg.st == med_pkg::MED_WATCH && activity) begin
                q_next.st        = med_pkg::MED_DOZE;
                q_next.sleep_cnt = 8'h00;
                ev_as            = 1'b1;
            end else if (q_reg.st == med_pkg::MED_DOZE) begin
                if (activity) begin
                    q_next.sleep_cnt = 8'h00;
                end else if (q_reg.sleep_cnt >= q_reg.sleep_lim) begin
                    if (q_reg.mode[`MED_MODE_WATCH]) begin
                        q_next.st = med_pkg::MED_WATCH;
                        ev_as     = 1'b1;
                    end
                end else begin
                    q_next.sleep_cnt = q_reg.sleep_cnt + 8'h01;
                end
            end
        end else begin
            activity = 1'b0;
        end

        if ((pl_chg && q_reg.irq_en[`MED_EN_PL]) || (fb_chg && q_reg.irq_en[`MED_EN_FB]) ||
            ev_shake || (ev_tap && q_reg.irq_en[`MED_EN_TAP]) ||
            (ev_as && q_reg.irq_en[`MED_EN_AS]) || (q_reg.smp_go && q_reg.irq_en[`MED_EN_G])) begin
            q_next.pend = 1'b1;
        end

        // register writes; mode at any time, other configuration only while standing by
        if (REG_REQ.wr) begin
            if (REG_REQ.addr == `MED_ADDR_MODE) begin
                q_next.mode = REG_REQ.wdata;
            end else if (!q_reg.mode[`MED_MODE_ON]) begin
                case (REG_REQ.addr)
                    `MED_ADDR_SLEEP: begin
                        // new limit restarts the sleep count
                        q_next.sleep_lim = REG_REQ.wdata;
                        q_next.sleep_cnt = 8'h00;
                    end
                    `MED_ADDR_IRQ:    q_next.irq_en   = REG_REQ.wdata;
                    `MED_ADDR_RATE:   q_next.rate_cfg = REG_REQ.wdata;
                    `MED_ADDR_TAPTH:  q_next.tap_cfg  = REG_REQ.wdata;
                    `MED_ADDR_TAPDUR: q_next.tap_dur  = REG_REQ.wdata;
                    default:         ;
                endcase
            end
        end

        // read mux; alert flags a read that collides with an update
        case (REG_REQ.addr)
            `MED_ADDR_X:     rd_val = {1'b0, axis_upd, q_reg.smp.x};
            `MED_ADDR_Y:     rd_val = {1'b0, axis_upd, q_reg.smp.y};
            `MED_ADDR_Z:     rd_val = {1'b0, axis_upd, q_reg.smp.z};
            `MED_ADDR_STAT:  rd_val = {q_reg.shake, ori_upd | ev_shake | ev_tap, q_reg.tap,
                                       q_reg.pl_code, q_reg.fb_code};
            `MED_ADDR_SRST:  rd_val = {6'h00, q_reg.st == med_pkg::MED_WATCH,
                                       q_reg.st == med_pkg::MED_ACTIVE ||
                                       q_reg.st == med_pkg::MED_DOZE};
            `MED_ADDR_SLEEP:  rd_val = q_reg.sleep_lim;
            `MED_ADDR_IRQ:    rd_val = q_reg.irq_en;
            `MED_ADDR_MODE:   rd_val = q_reg.mode;
            `MED_ADDR_RATE:   rd_val = q_reg.rate_cfg;
            `MED_ADDR_TAPTH:  rd_val = q_reg.tap_cfg;
            `MED_ADDR_TAPDUR: rd_val = q_reg.tap_dur;
            default:         rd_val = 8'h00;
        endcase
        if (REG_REQ.rd) begin
            q_next.rdata = rd_val;
        end

        // pin drive: push-pull follows polarity, open drain only pulls low
        q_next.int_oe = q_next.mode[`MED_MODE_IPP] | q_next.pend;
        q_next.int_o  = q_next.mode[`MED_MODE_IPP] &
                        (q_next.pend ~^ q_next.mode[`MED_MODE_IAH]);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign REG_RDATA = q_reg.rdata;
    assign INT_O     = q_reg.int_o;
    assign INT_OE    = q_reg.int_oe;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);

    a_shake_gated: assert property ($rose(q_reg.shake) |-> $past(q_reg.irq_en[7:5]) != 3'h0)
        else $error("shake set with no axis enabled");
    a_stat_read_clr: assert property ((stat_rd && !q_reg.smp_go) |=> !q_reg.shake && !q_reg.pend)
        else $error("status read left shake or interrupt set");
    a_no_sample_idle: assert property (!active |=> !q_reg.burst)
        else $error("sampling outside measurement");
    a_filt_direct: assert property ((q_reg.smp_go && q_reg.rate_cfg[7:5] == 3'h0)
        |=> {q_reg.pl_code, q_reg.fb_code} == $past(cand))
        else $error("orientation not stored with zero debounce");
    a_tap_pause: assert property ((q_reg.tap && !stat_rd) |=> q_reg.tap && $stable(q_reg.tap_cnt))
        else $error("tap detection ran while tap flag set");
    a_irq_gated: assert property ($rose(q_reg.pend) |-> $past(q_reg.irq_en) != 8'h00)
        else $error("interrupt with no enable set");
    a_watch_start: assert property ((q_reg.st == med_pkg::MED_STANDBY && active &&
        q_reg.mode[`MED_MODE_WATCH]) |=> q_reg.st == med_pkg::MED_WATCH)
        else $error("measurement did not start in watch");
    a_sleep_wr_rst: assert property ((REG_REQ.wr && REG_REQ.addr == `MED_ADDR_SLEEP &&
        !q_reg.mode[`MED_MODE_ON]) |=> q_reg.sleep_cnt == 8'h00)
        else $error("limit write did not reset sleep count");
    a_irq_holds: assert property ((q_reg.pend && !stat_rd) |=> q_reg.pend ##1 INT_OE == q_reg.int_oe)
        else $error("interrupt dropped before status read");
    a_sample_update_irq_en_fire: assert property ((q_reg.smp_go && q_reg.irq_en[`MED_EN_G]) |=> q_reg.pend)
        else $error("sample update interrupt missing");

endmodule : med_top

// ==== tb/med_host_model.sv ====
// Register host model issuing single-byte accesses
`timescale 1ns/100ps
module med_host_model (
    // clock
    input  wire logic          CLK_SYS,
    // register port
    output med_pkg::med_req_t  REG_REQ,
    input  wire logic [7:0]    REG_RDATA
);
    // ****************
    // access tasks
    // ****************
    // idle until the first strobe
    initial REG_REQ = '0;
    // one-cycle write strobe launched just after an edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge CLK_SYS) #1;
        REG_REQ = '{1'b0, 1'b1, a, d};
        @(posedge CLK_SYS) #1;
        REG_REQ = '0;
    endtask : wr
    // read data lands on the edge that takes the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge CLK_SYS) #1;
        REG_REQ = '{1'b1, 1'b0, a, 8'h00};
        @(posedge CLK_SYS) #1;
        REG_REQ = '0;
        d = REG_RDATA;
    endtask : rd
endmodule : med_host_model

// ==== tb/testbench.sv ====
// Self-checking bench of the motion event detector
`timescale 1ns/100ps
module testbench;
    logic               clk_sys;
    logic               reset_n;
    logic               adc_valid;
    med_pkg::med_axes_t adc_sample;
    med_pkg::med_req_t  reg_req;
    logic [7:0]         reg_rdata;
    logic [7:0]         d;
    logic               int_o;
    logic               int_oe;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    int                 cycles = 0;
    // fastest interval once the time base is one cycle per microsecond
    localparam int T = 8360;

    med_top #(.CYC_PER_US(1)) med_top_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .ADC_VALID(adc_valid), .ADC_SAMPLE(adc_sample), .REG_REQ(reg_req),
        .REG_RDATA(reg_rdata), .INT_O(int_o), .INT_OE(int_oe));
    med_host_model med_host_model_i (.CLK_SYS(clk_sys), .REG_REQ(reg_req),
        .REG_RDATA(reg_rdata));

    // ****************
    // clock, timeout, helpers
    // ****************
    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // a hang ends the run well past the expected length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            results();
        end
    end
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        med_host_model_i.rd(a, d);
        check($sformatf("reg %h", a), d, e);
    endtask : rchk
    // just after an interval's sample update, clear of any update edge
    task automatic wait_smp(input int n);
        repeat (n * T + 40) @(posedge clk_sys);
        #1;
    endtask : wait_smp
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // ****************
    // main sequence
    // ****************
    // converter runs continuously; only the mode decides what is sampled
    initial begin
        reset_n = 1'b0;
        adc_valid = 1'b0;
        adc_sample = '{6'sh1E, 6'sh00, 6'sh00};
        repeat (8) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        adc_valid = 1'b1;
        rchk(5'h07, 8'h00);
        rchk(5'h06, 8'h00);
        rchk(5'h1F, 8'h00);
        // shake x, landscape and face enables, fastest rate, no debounce
        med_host_model_i.wr(5'h06, 8'h83);
        med_host_model_i.wr(5'h08, 8'h00);
        med_host_model_i.wr(5'h07, 8'h01);
        med_host_model_i.wr(5'h06, 8'hFF);
        rchk(5'h06, 8'h83);
        wait_smp(1);
        check("int_oe", {7'h00, int_oe}, 8'h01);
        rchk(5'h00, 8'h1E);
        rchk(5'h03, 8'h94);
        repeat (3) @(posedge clk_sys);
        #1;
        check("int_oe", {7'h00, int_oe}, 8'h00);
        // standby: nothing new may be sampled
        med_host_model_i.wr(5'h07, 8'h00);
        adc_sample = '{6'sh00, 6'sh14, 6'sh36};
        med_host_model_i.wr(5'h08, 8'h60);
        wait_smp(1);
        rchk(5'h00, 8'h1E);
        // debounce of three readings before the left/back code is stored
        med_host_model_i.wr(5'h07, 8'h01);
        wait_smp(1);
        rchk(5'h03, 8'h14);
        wait_smp(3);
        check("int_oe", {7'h00, int_oe}, 8'h01);
        rchk(5'h03, 8'h06);
        rchk(5'h01, 8'h14);
        rchk(5'h02, 8'h36);
        results();
    end
endmodule : testbench
